// >>> rtl/psfs_top.sv
`timescale 1ns/10ps

// How it works
// - three 8-bit registers, four 2-bit fields in each
// - port A pin 7: capture or analog 7
// - port A pin 6: ext clock or analog 6
// - port B pin 3: code 01 gives SCL
// - port B pin 2: code 01 gives SDA
// - port B pin 1: code 01 inverted timer
// - port B pin 0: timer out or irq1
module psfs_top
	import psfs_pkg::*;
(
	// clock and reset
	input  wire logic               clk,
	input  wire logic               rst,

	// register port
	input  wire logic [ADDR_W-1:0]  reg_addr,
	input  wire logic [DATA_W-1:0]  reg_wdata,
	input  wire logic               reg_wr,
	input  wire logic               reg_rd,
	output logic      [DATA_W-1:0]  reg_rdata,

	// port A pins
	input  wire logic [PA_PINS-1:0] porta_pin_in,
	output logic      [PA_PINS-1:0] porta_pin_out,
	output logic      [PA_PINS-1:0] porta_pin_oe_n,

	// port A general i/o side
	input  wire logic [PA_PINS-1:0] gpio_a_out,
	input  wire logic [PA_PINS-1:0] gpio_a_oe_n,
	output logic      [PA_PINS-1:0] gpio_a_in,
	output logic      [PA_PINS-1:0] porta_analog_en,

	// port B pins
	input  wire logic [PB_PINS-1:0] portb_pin_in,
	output logic      [PB_PINS-1:0] portb_pin_out,
	output logic      [PB_PINS-1:0] portb_pin_oe_n,

	// port B general i/o side
	input  wire logic [PB_PINS-1:0] gpio_b_out,
	input  wire logic [PB_PINS-1:0] gpio_b_oe_n,
	output logic      [PB_PINS-1:0] gpio_b_in,

	// timer 1
	input  wire logic               timer1_out,
	input  wire logic               timer1_out_inverted,
	output logic                    timer1_capture_in,
	output logic                    timer1_ext_clock_in,

	// external interrupts
	output logic                    ext_irq0_input,
	output logic                    ext_irq1_input,

	// i2c
	input  wire logic               i2c_scl_drive_low,
	input  wire logic               i2c_sda_drive_low,
	output logic                    i2c_scl_in,
	output logic                    i2c_sda_in
);

	psfs_state_s q;
	psfs_state_s d;

	// field of a pin inside one selection register
	function automatic logic [FLD_W-1:0] field_of(
		input logic [DATA_W-1:0] sel,
		input int                idx
	);
		logic [FLD_W-1:0] f;
		f = SEL_GPIO;
		case (idx)
			0: f = sel[FLD_PIN0_LSB +: FLD_W];
			1: f = sel[FLD_PIN1_LSB +: FLD_W];
			2: f = sel[FLD_PIN2_LSB +: FLD_W];
			3: f = sel[FLD_PIN3_LSB +: FLD_W];
			default: f = SEL_GPIO;
		endcase
		return f;
	endfunction

	// code that hands the pin to the analog channel
	function automatic logic is_analog(input logic [FLD_W-1:0] f);
		return f == SEL_ANALOG;
	endfunction

	// code that hands the pin to the alternate peripheral
	function automatic logic is_alt(input logic [FLD_W-1:0] f);
		return f == SEL_ALT;
	endfunction

	// index that names one of the selection registers
	function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
		return a == REG_PA_LOW || a == REG_PA_HIGH || a == REG_PB;
	endfunction

	logic [FLD_W-1:0] pa_fld [PA_PINS];
	logic [FLD_W-1:0] pb_fld [PB_PINS];

	// field decode per pin
	genvar gi;
	generate
		for (gi = 0; gi < PA_PINS; gi++) begin : g_pa_fld
			if (gi < FLDS_PER_REG) begin : g_low
				assign pa_fld[gi] = field_of(q.porta_low_sel, gi);
			end else begin : g_high
				assign pa_fld[gi] = field_of(q.porta_high_sel,
					gi - FLDS_PER_REG);
			end
		end

		for (gi = 0; gi < PB_PINS; gi++) begin : g_pb_fld
			assign pb_fld[gi] = field_of(q.portb_sel, gi);
		end
	endgenerate

	always_comb begin
		d = q;

		// register read, data in the next cycle only
		d.rdata = RDATA_UNMAPPED;
		if (reg_rd && is_mapped(reg_addr)) begin
			case (reg_addr)
				REG_PA_LOW: begin
					d.rdata = q.porta_low_sel;
				end
				REG_PA_HIGH: begin
					d.rdata = q.porta_high_sel;
				end
				REG_PB: begin
					d.rdata = q.portb_sel;
				end
				default: begin
					d.rdata = RDATA_UNMAPPED;
				end
			endcase
		end

		if (reg_wr && is_mapped(reg_addr)) begin
			case (reg_addr)
				REG_PA_LOW: begin
					d.porta_low_sel = reg_wdata;
				end
				REG_PA_HIGH: begin
					d.porta_high_sel = reg_wdata;
				end
				REG_PB: begin
					d.portb_sel = reg_wdata;
				end
				default: begin
					d.portb_sel = q.portb_sel;
				end
			endcase
		end

		for (int k = 0; k < PA_PINS; k++) begin
			d.analog_en[k] = is_analog(pa_fld[k]);
			d.pa_out[k] = gpio_a_out[k];
			case (pa_fld[k])
				SEL_ANALOG: begin
					d.pa_oe_n[k] = 1'b1;
					d.gpio_a_in[k] = PERIPH_IN_IDLE;
				end
				default: begin
					d.pa_oe_n[k] = gpio_a_oe_n[k];
					d.gpio_a_in[k] = porta_pin_in[k];
				end
			endcase
		end

		// pin 4 shares irq0 unless analog
		case (pa_fld[4])
			SEL_ANALOG: begin
				d.irq0_in = PERIPH_IN_IDLE;
			end
			default: begin
				d.irq0_in = porta_pin_in[4];
			end
		endcase

		case (pa_fld[7])
			SEL_ANALOG: begin
				d.cap_in = PERIPH_IN_IDLE;
			end
			default: begin
				d.cap_in = porta_pin_in[7];
			end
		endcase

		case (pa_fld[6])
			SEL_ANALOG: begin
				d.clk_in = PERIPH_IN_IDLE;
			end
			default: begin
				d.clk_in = porta_pin_in[6];
			end
		endcase

		// port B defaults: general i/o
		for (int k = 0; k < PB_PINS; k++) begin
			d.pb_out[k] = gpio_b_out[k];
			d.pb_oe_n[k] = gpio_b_oe_n[k];
			d.gpio_b_in[k] = portb_pin_in[k];
		end

		// scl open drain on pin 3
		if (is_alt(pb_fld[3])) begin
			d.pb_out[3] = 1'b0;
			d.pb_oe_n[3] = ~i2c_scl_drive_low;
			d.gpio_b_in[3] = PERIPH_IN_IDLE;
			d.scl_in = portb_pin_in[3];
		end else begin
			d.scl_in = I2C_IN_IDLE;
		end

		// sda open drain on pin 2
		if (is_alt(pb_fld[2])) begin
			d.pb_out[2] = 1'b0;
			d.pb_oe_n[2] = ~i2c_sda_drive_low;
			d.gpio_b_in[2] = PERIPH_IN_IDLE;
			d.sda_in = portb_pin_in[2];
		end else begin
			d.sda_in = I2C_IN_IDLE;
		end

		// inverted timer drive on pin 1
		if (is_alt(pb_fld[1])) begin
			d.pb_out[1] = timer1_out_inverted;
			d.pb_oe_n[1] = 1'b0;
			d.gpio_b_in[1] = PERIPH_IN_IDLE;
		end

		// timer drive or irq1 on pin 0
		if (is_alt(pb_fld[0])) begin
			d.pb_out[0] = timer1_out;
			d.pb_oe_n[0] = 1'b0;
			d.gpio_b_in[0] = PERIPH_IN_IDLE;
			d.irq1_in = PERIPH_IN_IDLE;
		end else begin
			d.irq1_in = portb_pin_in[0];
		end
	end

	// state register, reset releases every pin
	always_ff @(posedge clk) begin
		if (rst) begin
			q.porta_low_sel <= SEL_RESET;
			q.porta_high_sel <= SEL_RESET;
			q.portb_sel <= SEL_RESET;

			q.rdata <= RDATA_UNMAPPED;

			q.pa_out <= '0;
			q.pa_oe_n <= '1;
			q.gpio_a_in <= '0;
			q.analog_en <= '0;

			q.pb_out <= '0;
			q.pb_oe_n <= '1;
			q.gpio_b_in <= '0;

			q.cap_in <= PERIPH_IN_IDLE;
			q.clk_in <= PERIPH_IN_IDLE;
			q.irq0_in <= PERIPH_IN_IDLE;
			q.irq1_in <= PERIPH_IN_IDLE;
			q.scl_in <= I2C_IN_IDLE;
			q.sda_in <= I2C_IN_IDLE;
		end else begin
			q <= d;
		end
	end

	// outputs straight from the state
	assign reg_rdata = q.rdata;

	assign porta_pin_out = q.pa_out;
	assign porta_pin_oe_n = q.pa_oe_n;
	assign gpio_a_in = q.gpio_a_in;
	assign porta_analog_en = q.analog_en;

	assign portb_pin_out = q.pb_out;
	assign portb_pin_oe_n = q.pb_oe_n;
	assign gpio_b_in = q.gpio_b_in;

	assign timer1_capture_in = q.cap_in;
	assign timer1_ext_clock_in = q.clk_in;

	assign ext_irq0_input = q.irq0_in;
	assign ext_irq1_input = q.irq1_in;

	assign i2c_scl_in = q.scl_in;
	assign i2c_sda_in = q.sda_in;

endmodule

// >>> pkg/psfs_pkg.sv
package psfs_pkg;

	// register port geometry
	localparam int ADDR_W = 2;
	localparam int DATA_W = 8;
	localparam int PA_PINS = 8;
	localparam int PB_PINS = 4;
	localparam int FLD_W = 2;
	localparam int FLDS_PER_REG = 4;

	// register indexes on the register port
	localparam logic [ADDR_W-1:0] REG_PA_LOW  = 2'h0;
	localparam logic [ADDR_W-1:0] REG_PA_HIGH = 2'h1;
	localparam logic [ADDR_W-1:0] REG_PB      = 2'h2;

	// reset and unmapped read values
	localparam logic [DATA_W-1:0] SEL_RESET     = 8'h00;
	localparam logic [DATA_W-1:0] RDATA_UNMAPPED = 8'h00;

	// field low-bit positions inside a selection register
	localparam int FLD_PIN0_LSB = 0;
	localparam int FLD_PIN1_LSB = 2;
	localparam int FLD_PIN2_LSB = 4;
	localparam int FLD_PIN3_LSB = 6;

	// field codes
	localparam logic [FLD_W-1:0] SEL_GPIO   = 2'h0;
	localparam logic [FLD_W-1:0] SEL_ALT    = 2'h1;
	localparam logic [FLD_W-1:0] SEL_GPIO2  = 2'h2;
	localparam logic [FLD_W-1:0] SEL_ANALOG = 2'h3;

	// idle levels of inputs handed to peripherals when the pin is taken
	localparam logic PERIPH_IN_IDLE = 1'b0;
	localparam logic I2C_IN_IDLE    = 1'b1;

	// whole state of the selector
	typedef struct packed {
		logic [DATA_W-1:0]  porta_low_sel;
		logic [DATA_W-1:0]  porta_high_sel;
		logic [DATA_W-1:0]  portb_sel;
		logic [DATA_W-1:0]  rdata;
		logic [PA_PINS-1:0] pa_out;
		logic [PA_PINS-1:0] pa_oe_n;
		logic [PA_PINS-1:0] gpio_a_in;
		logic [PA_PINS-1:0] analog_en;
		logic [PB_PINS-1:0] pb_out;
		logic [PB_PINS-1:0] pb_oe_n;
		logic [PB_PINS-1:0] gpio_b_in;
		logic               cap_in;
		logic               clk_in;
		logic               irq0_in;
		logic               irq1_in;
		logic               scl_in;
		logic               sda_in;
	} psfs_state_s;

endpackage

// >>> bench/psfs_chk.sv
`timescale 1ns/10ps
module psfs_chk (
	// register port
	input logic       clk,
	input logic       rst,
	input logic [1:0] reg_addr,
	input logic [7:0] reg_wdata,
	input logic       reg_wr,
	input logic       reg_rd,
	input logic [7:0] reg_rdata,
	// pins and peripherals
	input logic [7:0] porta_pin_in,
	input logic [7:0] porta_pin_oe_n,
	input logic [7:0] porta_analog_en,
	input logic       timer1_capture_in,
	input logic       timer1_ext_clock_in,
	input logic [3:0] portb_pin_in,
	input logic [3:0] portb_pin_out,
	input logic [3:0] portb_pin_oe_n,
	input logic       timer1_out,
	input logic       i2c_scl_drive_low,
	input logic       i2c_scl_in
);
	logic [7:0] pah_q;
	logic [7:0] pb_q;
	always_ff @(posedge clk) begin
		if (rst) begin
			pah_q <= 8'h00;
			pb_q <= 8'h00;
		end else if (reg_wr && reg_addr == 2'h1) begin
			pah_q <= reg_wdata;
		end else if (reg_wr && reg_addr == 2'h2) begin
			pb_q <= reg_wdata;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_wr_rd;
		reg_wr && reg_addr != 2'h3 ##1 reg_rd && $stable(reg_addr);
	endsequence
	property p_rd_idle;
		!$past(reg_rd) |-> reg_rdata == 8'h00;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("rdata");
	property p_wr_rd;
		s_wr_rd |=> reg_rdata == $past(reg_wdata, 2);
	endproperty
	a_wr_rd: assert property (p_wr_rd) else $error("readback");
	property p_an7;
		pah_q[7:6] == 2'h3 |=> porta_analog_en[7] && !timer1_capture_in;
	endproperty
	a_an7: assert property (p_an7) else $error("analog 7");
	property p_cap;
		pah_q[7:6] != 2'h3 |=> timer1_capture_in == $past(porta_pin_in[7]);
	endproperty
	a_cap: assert property (p_cap) else $error("capture");
	property p_an6;
		pah_q[5:4] == 2'h3 |=> porta_pin_oe_n[6] && !timer1_ext_clock_in;
	endproperty
	a_an6: assert property (p_an6) else $error("analog 6");
	property p_scl;
		pb_q[7:6] == 2'h1 |=> i2c_scl_in == $past(portb_pin_in[3])
			&& portb_pin_oe_n[3] != $past(i2c_scl_drive_low);
	endproperty
	a_scl: assert property (p_scl) else $error("scl");
	property p_scl_off;
		pb_q[7:6] != 2'h1 |=> i2c_scl_in;
	endproperty
	a_scl_off: assert property (p_scl_off) else $error("scl idle");
	property p_t1;
		pb_q[1:0] == 2'h1 |=> portb_pin_out[0] == $past(timer1_out);
	endproperty
	a_t1: assert property (p_t1) else $error("timer out");
endmodule

bind psfs_top psfs_chk psfs_chk_i (.clk, .rst, .reg_addr, .reg_wdata,
	.reg_wr, .reg_rd, .reg_rdata, .porta_pin_in, .porta_pin_oe_n,
	.porta_analog_en, .timer1_capture_in, .timer1_ext_clock_in,
	.portb_pin_in, .portb_pin_out, .portb_pin_oe_n, .timer1_out,
	.i2c_scl_drive_low, .i2c_scl_in);

// >>> bench/pin_shared_function_select_tb.sv
`timescale 1ns/10ps
module pin_shared_function_select_tb;
	logic        clk, rst, reg_wr, reg_rd, esc, esd;
	logic [1:0]  reg_addr;
	logic [7:0]  reg_wdata, reg_rdata, porta_pin_in, porta_pin_out;
	logic [7:0]  porta_pin_oe_n, gpio_a_out, gpio_a_oe_n, gpio_a_in;
	logic [7:0]  porta_analog_en, er, ea, eoe, egi, ean, sm [4];
	logic [3:0]  portb_pin_in, portb_pin_out, portb_pin_oe_n, gpio_b_out;
	logic [3:0]  gpio_b_oe_n, gpio_b_in, ebo, eboe, ebi, tk;
	logic        timer1_out, timer1_out_inverted, timer1_capture_in;
	logic        timer1_ext_clock_in, ext_irq0_input, ext_irq1_input;
	logic        i2c_scl_drive_low, i2c_sda_drive_low, i2c_scl_in, i2c_sda_in;
	logic [39:0] rin;
	int          n_mismatch, comparisons, cyc, k, i, op;
	assign {porta_pin_in, gpio_a_out, gpio_a_oe_n, portb_pin_in, gpio_b_out,
		gpio_b_oe_n, timer1_out, timer1_out_inverted, i2c_scl_drive_low,
		i2c_sda_drive_low} = rin;
	psfs_top psfs_top_i (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .porta_pin_in, .porta_pin_out, .porta_pin_oe_n,
		.gpio_a_out, .gpio_a_oe_n, .gpio_a_in, .porta_analog_en,
		.portb_pin_in, .portb_pin_out, .portb_pin_oe_n, .gpio_b_out,
		.gpio_b_oe_n, .gpio_b_in, .timer1_out, .timer1_out_inverted,
		.timer1_capture_in, .timer1_ext_clock_in, .ext_irq0_input,
		.ext_irq1_input, .i2c_scl_drive_low, .i2c_sda_drive_low,
		.i2c_scl_in, .i2c_sda_in);
	task complete_run();
		$display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task cmp_rd(input logic [7:0] g, input logic [7:0] e);
		comparisons++;
		if (g !== e) begin
			n_mismatch++;
			$display("BAD %0t got %h exp %h", $time, g, e);
		end
	endtask
	task cmp_pin(input logic [23:0] g, input logic [23:0] e);
		comparisons++;
		if (g !== e) begin
			n_mismatch++;
			$display("BAD %0t got %h exp %h", $time, g, e);
		end
	endtask
	task cmp_per(input logic [15:0] g, input logic [15:0] e);
		comparisons++;
		if (g !== e) begin
			n_mismatch++;
			$display("BAD %0t got %h exp %h", $time, g, e);
		end
	endtask
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// reference model, outputs one edge behind inputs
	always @(posedge clk) begin
		cyc++;
		if (cyc > 4000) begin
			n_mismatch++;
			complete_run();
		end else if (rst) begin
			sm = '{default: 8'h00};
			{er, ea, egi, ean, ebo, ebi} = '0;
			{eoe, eboe, esc, esd} = '1;
		end else begin
			er = reg_rd ? sm[reg_addr] : 8'h00;
			for (k = 0; k < 8; k++) begin
				ean[k] = sm[k / 4][2 * (k % 4) +: 2] == 2'h3;
				ea[k] = gpio_a_out[k] & ~gpio_a_oe_n[k] & ~ean[k];
				eoe[k] = gpio_a_oe_n[k] | ean[k];
				egi[k] = porta_pin_in[k] & ~ean[k];
			end
			for (k = 0; k < 4; k++) begin
				tk[k] = sm[2][2 * k +: 2] == 2'h1;
				ebo[k] = ~tk[k] & gpio_b_out[k] & ~gpio_b_oe_n[k];
				eboe[k] = ~tk[k] & gpio_b_oe_n[k];
				ebi[k] = ~tk[k] & portb_pin_in[k];
			end
			if (tk[0]) ebo[0] = timer1_out;
			if (tk[1]) ebo[1] = timer1_out_inverted;
			if (tk[2]) eboe[2] = ~i2c_sda_drive_low;
			if (tk[3]) eboe[3] = ~i2c_scl_drive_low;
			esd = ~tk[2] | portb_pin_in[2];
			esc = ~tk[3] | portb_pin_in[3];
			if (reg_wr && reg_addr != 2'h3) sm[reg_addr] = reg_wdata;
		end
	end
	always @(negedge clk) begin
		if (cyc > 1) begin
			cmp_rd(reg_rdata, er);
			cmp_pin({porta_analog_en, porta_pin_oe_n,
				porta_pin_out & ~porta_pin_oe_n}, {ean, eoe, ea});
			cmp_per({gpio_a_in, 5'h00, timer1_capture_in,
				timer1_ext_clock_in, ext_irq0_input},
				{egi, 5'h00, egi[7], egi[6], egi[4]});
			cmp_pin({8'h00, portb_pin_out & ~portb_pin_oe_n,
				portb_pin_oe_n}, {8'h00, ebo, eboe});
			cmp_per({9'h000, gpio_b_in, ext_irq1_input,
				i2c_scl_in, i2c_sda_in}, {9'h000, ebi, ebi[0], esc, esd});
		end
	end
	initial begin
		{rst, reg_wr, reg_rd, reg_addr, reg_wdata} = 13'h1000;
		rin = '0;
		void'($urandom(93));
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		// reset values and the unmapped index
		for (i = 0; i < 4; i++) begin
			@(posedge clk);
			reg_rd <= 1'b1;
			reg_addr <= 2'(i);
		end
		for (i = 0; i < 3000; i++) begin
			@(posedge clk);
			op = $urandom % 3;
			rin <= op == 1 ? {36'({$urandom, $urandom}), 4'h0}
				: 40'({$urandom, $urandom});
			rst <= i >= 1500 && i < 1503;
			reg_wr <= op == 1;
			reg_rd <= op == 2;
			reg_addr <= 2'($urandom);
			reg_wdata <= 8'($urandom);
		end
		repeat (2) @(posedge clk);
		complete_run();
	end
endmodule
